// ===== inc/blsc_defines.svh
// constant definitions for the bridge lock and system error control block
`ifndef BLSC_DEFINES_SVH
`define BLSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define BLSC_OFF_CTRL       12'h000
`define BLSC_OFF_STATUS     12'h004
`define BLSC_OFF_CAUSE      12'h008
`define BLSC_OFF_DISABLE    12'h00c
`define BLSC_OFF_LOCKSTAT   12'h010
// the lock option register keeps its printed index, the byte address is four times it
`define BLSC_IDX_LOCKOPT    12'h046
`define BLSC_OFF_LOCKOPT    12'h118

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define BLSC_CTRL_W         6
`define BLSC_CTRL_RST       6'h00
`define BLSC_LOCKOPT_DN_BIT 13
`define BLSC_LOCKOPT_UP_BIT 14
`define BLSC_LOCKOPT_RST    2'h0
`define BLSC_ST_SIGNALED    0
`define BLSC_ST_RECEIVED    1
`define BLSC_ST_LK_TABORT   2
`define BLSC_ST_LK_MABORT   3
`define BLSC_ST_W           4
`define BLSC_EVT_W          8
`define BLSC_EVT_RST        8'h00
`define BLSC_RETRY_LIMIT    (2 ** 24)
`define BLSC_RETRY_CNT_W    25

`endif

// ===== inc/blsc_pkg.sv
// types shared by the bridge lock and system error control block
package blsc_pkg;

	// ----------------------------------------------------------------------------
	// software controls
	// ----------------------------------------------------------------------------
	typedef struct packed {
		logic mto_serr_en;
		logic master_abort_mode;
		logic serr_fwd_en;
		logic perr_resp_sec;
		logic perr_resp_pri;
		logic serr_en;
	} blsc_ctrl_t;

	// ----------------------------------------------------------------------------
	// system error causes, one bit each, same order as the cause register
	// ----------------------------------------------------------------------------
	typedef struct packed {
		logic mto;
		logic dr_retry_limit;
		logic dw_retry_limit;
		logic pw_parity;
		logic pw_retry_limit;
		logic pw_mabort;
		logic pw_tabort;
		logic fwd;
	} blsc_evt_t;

	// ----------------------------------------------------------------------------
	// crossing lock sequencer
	// ----------------------------------------------------------------------------
	typedef enum logic [6:0] {
		LK_IDLE       = 7'h01,
		LK_QUEUED     = 7'h02,
		LK_WAIT_BUS   = 7'h04,
		LK_ADDR       = 7'h08,
		LK_FIRST      = 7'h10,
		LK_TGT_LOCKED = 7'h20,
		LK_LOCKED     = 7'h40
	} blsc_lk_state_t;

endpackage : blsc_pkg

// ===== verilog/blsc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module blsc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_rst_val,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;

	always_comb begin
		for (int k = 0; k < W; k++) begin
			out_d[k] = (s2_q[k] == s3_q[k]) ? s3_q[k] : out_q[k];
		end
	end

	// pins are pulled up, so the inactive high level is the reset value
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			out_q <= '1;
		end else begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign o_sync = out_q;
endmodule : blsc_sync

// ===== verilog/blsc_syserr.sv
// primary system error gating and cause recording
`timescale 1ns/1ns
`include "blsc_defines.svh"
module blsc_syserr (
	input  wire logic                   i_clk,
	input  wire logic                   i_nrst,
	input  wire blsc_pkg::blsc_evt_t     i_evt,
	input  wire blsc_pkg::blsc_ctrl_t    i_ctrl,
	input  wire logic [`BLSC_EVT_W-1:0] i_disable,
	input  wire logic [`BLSC_EVT_W-1:0] i_cause_clr,
	output logic      [`BLSC_EVT_W-1:0] o_cause,
	output logic                        o_assert
);
	logic [`BLSC_EVT_W-1:0] raw;
	logic [`BLSC_EVT_W-1:0] gate;
	logic [`BLSC_EVT_W-1:0] fire;
	logic [`BLSC_EVT_W-1:0] cause_q;
	logic [`BLSC_EVT_W-1:0] cause_d;
	logic                   assert_q;
	logic                   assert_d;

	always_comb begin
		raw  = i_evt;
		gate = ~i_disable;
		// master timeout has its own enable and ignores the disable register
		gate[`BLSC_EVT_W-1] = i_ctrl.mto_serr_en;
		gate[0] = gate[0] & i_ctrl.serr_fwd_en;
		// parity needs both response bits set
		gate[4] = gate[4] & i_ctrl.perr_resp_pri & i_ctrl.perr_resp_sec;
		fire     = (i_ctrl.serr_en) ? (raw & gate) : '0;
		assert_d = |fire;
		// a new cause wins over a clear in the same cycle
		cause_d  = (cause_q & ~i_cause_clr) | fire;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cause_q  <= `BLSC_EVT_RST;
			assert_q <= 1'b0;
		end else begin
			cause_q  <= cause_d;
			assert_q <= assert_d;
		end
	end

	assign o_cause  = cause_q;
	assign o_assert = assert_q;
endmodule : blsc_syserr

// ===== verilog/blsc_top.sv
// bridge lock sequencing and primary system error control, with its APB registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "blsc_defines.svh"
module blsc_top #(
	parameter int RETRY_LIMIT = `BLSC_RETRY_LIMIT
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_NRST,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// bus pins
	input  wire logic        I_SECONDARY_SYSERR_IN_N,
	input  wire logic        I_P_LOCK_N,
	input  wire logic        I_P_FRAME_N,
	input  wire logic        I_P_IRDY_N,
	input  wire logic        I_S_LOCK_N,
	input  wire logic        I_S_FRAME_N,
	input  wire logic        I_S_IRDY_N,
	output logic             O_PRIMARY_SYSERR_OUT_N,
	output logic             O_PRIMARY_SYSERR_OE,
	output logic             O_P_LOCK_N_OUT,
	output logic             O_P_LOCK_OE,
	output logic             O_S_LOCK_N_OUT,
	output logic             O_S_LOCK_OE,
	// lock events from the queues and masters
	input  wire logic        I_LK_REQ,
	input  wire logic        I_LK_REQ_DIR,
	input  wire logic        I_LK_REQ_READ,
	input  wire logic        I_PRIOR_DONE,
	input  wire logic        I_TGT_ADDR,
	input  wire logic        I_TGT_DATA_DONE,
	input  wire logic        I_TGT_RETRY,
	input  wire logic        I_TGT_TABORT,
	input  wire logic        I_TGT_MABORT,
	input  wire logic        I_INI_REPEAT,
	input  wire logic        I_MTO,
	input  wire logic        I_PW_PENDING,
	// posted and delayed transaction outcomes
	input  wire logic        I_PW_LOCKED,
	input  wire logic        I_PW_DONE,
	input  wire logic        I_PW_RETRY,
	input  wire logic        I_PW_TABORT,
	input  wire logic        I_PW_MABORT,
	input  wire logic        I_PW_PARITY,
	input  wire logic        I_DLY_DONE,
	input  wire logic        I_DLY_RETRY,
	input  wire logic        I_DLY_IS_READ,
	output logic             O_LK_CAPTURE,
	output logic             O_LK_RETRY_ALL,
	output logic             O_LK_BUS_REQ,
	output logic             O_LK_NO_PREFETCH,
	output logic             O_LK_FWD_LOCKED,
	output logic             O_LK_DATA_RET,
	output logic             O_LK_TABORT_RET,
	output logic             O_LK_MABORT_RET,
	output logic             O_PW_DISCARD,
	output logic             O_DLY_DISCARD
);
	// ----------------------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------------------
	logic [6:0] pins;
	logic       serr_in_n;
	logic       p_lock_n;
	logic       p_frame_n;
	logic       p_irdy_n;
	logic       s_lock_n;
	logic       s_frame_n;
	logic       s_irdy_n;

	blsc_sync #(.W(7)) u_sync (
		.i_clk     (I_REF_CLK),
		.i_nrst    (I_NRST),
		.i_async   ({I_SECONDARY_SYSERR_IN_N, I_P_LOCK_N, I_P_FRAME_N, I_P_IRDY_N,
		             I_S_LOCK_N, I_S_FRAME_N, I_S_IRDY_N}),
		.i_rst_val ('1),
		.o_sync    (pins)
	);
	assign {serr_in_n, p_lock_n, p_frame_n, p_irdy_n, s_lock_n, s_frame_n, s_irdy_n} = pins;

	// ----------------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------------
	blsc_pkg::blsc_ctrl_t        ctrl_q;
	blsc_pkg::blsc_ctrl_t        ctrl_d;
	logic [1:0]                  lockopt_q;
	logic [1:0]                  lockopt_d;
	logic [`BLSC_EVT_W-1:0]      disable_q;
	logic [`BLSC_EVT_W-1:0]      disable_d;
	logic [`BLSC_ST_W-1:0]       status_q;
	logic [`BLSC_ST_W-1:0]       status_d;
	logic [31:0]                 prdata_q;
	logic [31:0]                 prdata_d;
	logic                        wr_acc;
	logic                        rd_setup;
	logic                        mapped;
	logic [`BLSC_EVT_W-1:0]      cause;
	logic [`BLSC_EVT_W-1:0]      cause_clr;
	logic                        syserr_fire;
	blsc_pkg::blsc_evt_t         evt;

	// ----------------------------------------------------------------------------
	// lock sequencer state
	// ----------------------------------------------------------------------------
	blsc_pkg::blsc_lk_state_t    st_q;
	blsc_pkg::blsc_lk_state_t    st_d;
	logic                        dir_q;
	logic                        dir_d;
	logic                        capture_q;
	logic                        capture_d;
	logic                        data_ret_q;
	logic                        data_ret_d;
	logic                        tab_ret_q;
	logic                        tab_ret_d;
	logic                        mab_ret_q;
	logic                        mab_ret_d;
	logic [1:0]                  abort_q;
	logic [1:0]                  abort_d;
	logic                        lk_tabort;
	logic                        lk_mabort;
	logic                        lk_mto;
	logic                        ignore;
	logic                        tgt_free;
	logic                        ini_idle;

	// zero wait states: every access phase finishes on its first edge
	assign O_PREADY = 1'b1;
	assign wr_acc   = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;

	always_comb begin
		unique case (I_PADDR)
			`BLSC_OFF_CTRL, `BLSC_OFF_STATUS, `BLSC_OFF_CAUSE, `BLSC_OFF_DISABLE,
			`BLSC_OFF_LOCKSTAT, `BLSC_OFF_LOCKOPT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

	always_comb begin
		ctrl_d    = ctrl_q;
		lockopt_d = lockopt_q;
		disable_d = disable_q;
		cause_clr = '0;
		prdata_d  = prdata_q;
		if (wr_acc) begin
			unique case (I_PADDR)
				`BLSC_OFF_CTRL:    ctrl_d    = I_PWDATA[`BLSC_CTRL_W-1:0];
				`BLSC_OFF_DISABLE: disable_d = I_PWDATA[`BLSC_EVT_W-1:0];
				`BLSC_OFF_CAUSE:   cause_clr = I_PWDATA[`BLSC_EVT_W-1:0];
				`BLSC_OFF_LOCKOPT: lockopt_d = I_PWDATA[`BLSC_LOCKOPT_UP_BIT:`BLSC_LOCKOPT_DN_BIT];
				default: ;
			endcase
		end
		// read data is loaded in the setup cycle so it comes from a flop
		if (rd_setup) begin
			prdata_d = 32'h0000_0000;
			unique case (I_PADDR)
				`BLSC_OFF_CTRL:     prdata_d[`BLSC_CTRL_W-1:0] = ctrl_q;
				`BLSC_OFF_STATUS:   prdata_d[`BLSC_ST_W-1:0]   = status_q;
				`BLSC_OFF_CAUSE:    prdata_d[`BLSC_EVT_W-1:0]  = cause;
				`BLSC_OFF_DISABLE:  prdata_d[`BLSC_EVT_W-1:0]  = disable_q;
				`BLSC_OFF_LOCKSTAT: prdata_d[7:0]              = {dir_q, st_q};
				`BLSC_OFF_LOCKOPT:  prdata_d[`BLSC_LOCKOPT_UP_BIT:`BLSC_LOCKOPT_DN_BIT] = lockopt_q;
				default: ;
			endcase
		end
	end

	// status flags: hardware set wins over a write-one clear in the same cycle
	always_comb begin
		status_d = status_q;
		if (wr_acc && (I_PADDR == `BLSC_OFF_STATUS)) begin
			status_d = status_q & ~I_PWDATA[`BLSC_ST_W-1:0];
		end
		if (syserr_fire) begin
			status_d[`BLSC_ST_SIGNALED] = 1'b1;
		end
		if (~serr_in_n && ctrl_q.serr_fwd_en) begin
			status_d[`BLSC_ST_RECEIVED] = 1'b1;
		end
		if (lk_tabort) begin
			status_d[`BLSC_ST_LK_TABORT] = 1'b1;
		end
		if (lk_mabort) begin
			status_d[`BLSC_ST_LK_MABORT] = 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl_q    <= `BLSC_CTRL_RST;
			lockopt_q <= `BLSC_LOCKOPT_RST;
			disable_q <= `BLSC_EVT_RST;
			status_q  <= '0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			ctrl_q    <= ctrl_d;
			lockopt_q <= lockopt_d;
			disable_q <= disable_d;
			status_q  <= status_d;
			prdata_q  <= prdata_d;
		end
	end
	assign O_PRDATA = prdata_q;

	// ----------------------------------------------------------------------------
	// retry limit counters: posted writes and delayed transactions
	// ----------------------------------------------------------------------------
	logic [1:0] rty_ev;
	logic [1:0] rty_clr;
	logic [1:0] rty_hit;
	assign rty_ev  = {I_DLY_RETRY, I_PW_RETRY};
	assign rty_clr = {I_DLY_DONE, I_PW_DONE};

	for (genvar g = 0; g < 2; g++) begin : g_rty
		logic [`BLSC_RETRY_CNT_W-1:0] cnt_q;
		logic [`BLSC_RETRY_CNT_W-1:0] cnt_d;
		logic                         hit_q;
		logic                         hit_d;
		always_comb begin
			cnt_d = cnt_q;
			hit_d = 1'b0;
			if (rty_clr[g]) begin
				cnt_d = '0;
			end else if (rty_ev[g]) begin
				// limit reached: the data is dropped and the count starts over
				if (cnt_q == `BLSC_RETRY_CNT_W'(RETRY_LIMIT - 1)) begin
					cnt_d = '0;
					hit_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
		end
		always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
			if (!I_NRST) begin
				cnt_q <= '0;
				hit_q <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				hit_q <= hit_d;
			end
		end
		assign rty_hit[g] = hit_q;
	end
	assign O_PW_DISCARD  = rty_hit[0];
	assign O_DLY_DISCARD = rty_hit[1];

	// ----------------------------------------------------------------------------
	// system error events
	// ----------------------------------------------------------------------------
	logic dly_read_q;
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			dly_read_q <= 1'b0;
		end else begin
			dly_read_q <= I_DLY_IS_READ;
		end
	end

	always_comb begin
		evt.fwd            = ~serr_in_n;
		evt.pw_tabort      = I_PW_TABORT;
		// a locked posted master abort also needs master abort mode
		evt.pw_mabort      = I_PW_MABORT & (~I_PW_LOCKED | ctrl_q.master_abort_mode);
		evt.pw_retry_limit = rty_hit[0];
		evt.pw_parity      = I_PW_PARITY;
		evt.dw_retry_limit = rty_hit[1] & ~dly_read_q;
		evt.dr_retry_limit = rty_hit[1] & dly_read_q;
		evt.mto            = I_MTO | lk_mto;
	end

	blsc_syserr u_syserr (
		.i_clk       (I_REF_CLK),
		.i_nrst      (I_NRST),
		.i_evt       (evt),
		.i_ctrl      (ctrl_q),
		.i_disable   (disable_q),
		.i_cause_clr (cause_clr),
		.o_cause     (cause),
		.o_assert    (syserr_fire)
	);
	// open drain: only ever pulled low
	assign O_PRIMARY_SYSERR_OUT_N = 1'b0;
	assign O_PRIMARY_SYSERR_OE    = syserr_fire;

	// ----------------------------------------------------------------------------
	// crossing lock sequencer
	// ----------------------------------------------------------------------------
	// dir 0: downstream, target bus is secondary; dir 1: upstream
	assign ignore   = I_LK_REQ_DIR ? lockopt_q[1] : lockopt_q[0];
	assign tgt_free = dir_q ? (p_frame_n & p_irdy_n & p_lock_n) : (s_frame_n & s_irdy_n & s_lock_n);
	assign ini_idle = dir_q ? (s_lock_n & s_frame_n) : (p_lock_n & p_frame_n);
	assign lk_tabort = (st_q == blsc_pkg::LK_FIRST) & I_TGT_TABORT;
	assign lk_mabort = (st_q == blsc_pkg::LK_FIRST) & I_TGT_MABORT;
	assign lk_mto    = (st_q == blsc_pkg::LK_TGT_LOCKED) & I_MTO;

	always_comb begin
		st_d       = st_q;
		dir_d      = dir_q;
		capture_d  = 1'b0;
		data_ret_d = 1'b0;
		tab_ret_d  = 1'b0;
		mab_ret_d  = 1'b0;
		abort_d    = abort_q;
		// a pending aborted status goes back on the initiator's repeat
		if (|abort_q && I_INI_REPEAT) begin
			tab_ret_d = abort_q[0];
			mab_ret_d = abort_q[1];
			abort_d   = 2'b00;
		end
		unique case (st_q)
			blsc_pkg::LK_IDLE: begin
				// only a read may open a crossing lock; other locks stay local
				if (I_LK_REQ && I_LK_REQ_READ && !ignore) begin
					capture_d = 1'b1;
					dir_d     = I_LK_REQ_DIR;
					st_d      = blsc_pkg::LK_QUEUED;
				end
			end
			blsc_pkg::LK_QUEUED: begin
				if (I_PRIOR_DONE) begin
					st_d = blsc_pkg::LK_WAIT_BUS;
				end
			end
			blsc_pkg::LK_WAIT_BUS: begin
				if (I_TGT_ADDR) begin
					st_d = blsc_pkg::LK_ADDR;
				end
			end
			blsc_pkg::LK_ADDR: begin
				st_d = blsc_pkg::LK_FIRST;
			end
			blsc_pkg::LK_FIRST: begin
				if (I_TGT_DATA_DONE) begin
					st_d = blsc_pkg::LK_TGT_LOCKED;
				end else if (I_TGT_RETRY) begin
					st_d = blsc_pkg::LK_WAIT_BUS;
				end else if (I_TGT_TABORT || I_TGT_MABORT) begin
					abort_d = {I_TGT_MABORT, I_TGT_TABORT & ~I_TGT_MABORT};
					st_d    = blsc_pkg::LK_IDLE;
				end
			end
			blsc_pkg::LK_TGT_LOCKED: begin
				// the repeat is recognised on I_INI_REPEAT alone; the lock pins are not checked
				if (I_INI_REPEAT) begin
					data_ret_d = 1'b1;
					st_d       = blsc_pkg::LK_LOCKED;
				end else if (I_MTO) begin
					st_d = blsc_pkg::LK_IDLE;
				end
			end
			blsc_pkg::LK_LOCKED: begin
				// target retries here leave the lock alone
				if (I_PW_DONE && I_PW_LOCKED && ini_idle) begin
					st_d = blsc_pkg::LK_IDLE;
				end else if (ini_idle && !I_PW_PENDING) begin
					st_d = blsc_pkg::LK_IDLE;
				end
			end
			default: st_d = blsc_pkg::LK_IDLE;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_q       <= blsc_pkg::LK_IDLE;
			dir_q      <= 1'b0;
			capture_q  <= 1'b0;
			data_ret_q <= 1'b0;
			tab_ret_q  <= 1'b0;
			mab_ret_q  <= 1'b0;
			abort_q    <= 2'b00;
		end else begin
			st_q       <= st_d;
			dir_q      <= dir_d;
			capture_q  <= capture_d;
			data_ret_q <= data_ret_d;
			tab_ret_q  <= tab_ret_d;
			mab_ret_q  <= mab_ret_d;
			abort_q    <= abort_d;
		end
	end

	// ----------------------------------------------------------------------------
	// lock outputs
	// ----------------------------------------------------------------------------
	logic tgt_lock_oe;
	logic tgt_lock_low;
	assign tgt_lock_oe  = (st_q == blsc_pkg::LK_ADDR) | (st_q == blsc_pkg::LK_FIRST) |
	                      (st_q == blsc_pkg::LK_TGT_LOCKED) | (st_q == blsc_pkg::LK_LOCKED);
	// high in the address phase, low from the next cycle on
	assign tgt_lock_low = tgt_lock_oe & (st_q != blsc_pkg::LK_ADDR);
	assign O_S_LOCK_OE    = tgt_lock_oe & ~dir_q;
	assign O_S_LOCK_N_OUT = ~(tgt_lock_low & ~dir_q);
	assign O_P_LOCK_OE    = tgt_lock_oe & dir_q;
	assign O_P_LOCK_N_OUT = ~(tgt_lock_low & dir_q);

	assign O_LK_CAPTURE     = capture_q;
	assign O_LK_RETRY_ALL   = (st_q != blsc_pkg::LK_IDLE) & (st_q != blsc_pkg::LK_LOCKED);
	assign O_LK_BUS_REQ     = (st_q == blsc_pkg::LK_WAIT_BUS) & tgt_free;
	assign O_LK_NO_PREFETCH = (st_q != blsc_pkg::LK_IDLE);
	assign O_LK_FWD_LOCKED  = (st_q == blsc_pkg::LK_LOCKED);
	assign O_LK_DATA_RET    = data_ret_q;
	assign O_LK_TABORT_RET  = tab_ret_q;
	assign O_LK_MABORT_RET  = mab_ret_q;
endmodule : blsc_top

// ===== testbench/blsc_mon_monitor.sv
// checker of the block's system error and lock outputs
`timescale 1ns/1ns
module blsc_mon #(
	parameter int RETRY_LIMIT = 4
) (
	input wire logic I_REF_CLK, I_NRST, I_PSEL, I_PENABLE, I_PWRITE, I_PW_TABORT, I_LK_REQ, I_LK_REQ_READ,
	input wire logic I_SECONDARY_SYSERR_IN_N, O_PRIMARY_SYSERR_OE, O_LK_CAPTURE, O_LK_RETRY_ALL, O_LK_FWD_LOCKED,
	input wire logic O_LK_NO_PREFETCH, O_LK_DATA_RET, O_S_LOCK_OE, O_S_LOCK_N_OUT,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA
);
	// settings mirrored from completed writes
	logic [31:0] ctl_q, dis_q, opt_q;
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctl_q <= '0;
			dis_q <= '0;
			opt_q <= '0;
		end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
			if (I_PADDR == 12'h000) ctl_q <= I_PWDATA;
			if (I_PADDR == 12'h00c) dis_q <= I_PWDATA;
			if (I_PADDR == 12'h118) opt_q <= I_PWDATA;
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	a_serr_gate: assert property (O_PRIMARY_SYSERR_OE |-> $past(ctl_q[0]))
		else $error("system error while disabled");
	a_tabort_serr: assert property (I_PW_TABORT && ctl_q[0] && !dis_q[1] |=> O_PRIMARY_SYSERR_OE)
		else $error("posted abort not signalled");
	a_fwd_serr: assert property ($fell(I_SECONDARY_SYSERR_IN_N) && ctl_q[0] && ctl_q[3] && !dis_q[0]
		|-> ##[2:8] O_PRIMARY_SYSERR_OE) else $error("secondary error not forwarded");
	a_lock_capture: assert property (I_LK_REQ && I_LK_REQ_READ && !O_LK_RETRY_ALL && !O_LK_FWD_LOCKED
		&& !O_S_LOCK_OE && opt_q[14:13] == 2'b00 |=> O_LK_CAPTURE) else $error("locked request not captured");
	a_capture_retry: assert property (O_LK_CAPTURE |-> O_LK_RETRY_ALL)
		else $error("capture without retry");
	a_addr_unlocked: assert property ($rose(O_S_LOCK_OE) |-> O_S_LOCK_N_OUT ##1 !O_S_LOCK_N_OUT)
		else $error("lock order wrong on target bus");
	a_locked_noprefetch: assert property (O_LK_FWD_LOCKED |-> O_LK_NO_PREFETCH)
		else $error("prefetch while locked");
	a_data_locked: assert property (O_LK_DATA_RET |-> O_LK_FWD_LOCKED && !O_LK_RETRY_ALL)
		else $error("data returned without lock");
	a_reset_release: assert property (disable iff (1'b0) !I_NRST ##1 !I_NRST |-> !O_S_LOCK_OE && O_S_LOCK_N_OUT
		&& !O_PRIMARY_SYSERR_OE) else $error("outputs active in reset");
endmodule : blsc_mon
bind blsc_top blsc_mon #(.RETRY_LIMIT(RETRY_LIMIT)) mon_u (.*);

// ===== testbench/blsc_far.sv
// far-side model: initiator lock sequence and secondary bus pins
`timescale 1ns/1ns
module blsc_far (
	input  wire logic i_clk, i_hold, i_busy, i_serr, i_s_oe, i_s_out,
	output logic      o_p_lock_n, o_p_frame_n, o_s_lock_n, o_s_frame_n, o_secondary_syserr_in_n
);
	always_ff @(posedge i_clk) o_p_lock_n <= !i_hold; // lock one clock after the address phase
	assign o_p_frame_n = !(i_hold && o_p_lock_n); // address phase with lock still inactive
	// released lines settle at the pull-up level
	assign o_s_lock_n = i_s_oe ? i_s_out : !i_busy;
	assign o_s_frame_n = !i_busy;
	assign o_secondary_syserr_in_n = !i_serr;
endmodule : blsc_far

// ===== testbench/tb_top.sv
// self-checking bench of the lock and system error control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h seen %h", n, e, s); end end
module tb_top;
	localparam int RL = 4;
	logic I_REF_CLK = 0, I_NRST = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, O_PREADY, O_PSLVERR;
	logic [11:0] I_PADDR = 0;
	logic [31:0] I_PWDATA = 0, O_PRDATA, q;
	logic [14:0] pv = 0;
	wire I_LK_REQ = pv[0], I_TGT_ADDR = pv[1], I_TGT_DATA_DONE = pv[2], I_TGT_RETRY = pv[3], I_INI_REPEAT = pv[4];
	wire I_TGT_TABORT = pv[5], I_TGT_MABORT = pv[6], I_PW_DONE = pv[7], I_DLY_DONE = pv[8], I_PW_TABORT = pv[9];
	wire I_PW_MABORT = pv[10], I_PW_RETRY = pv[11], I_PW_PARITY = pv[12], I_DLY_RETRY = pv[13], I_MTO = pv[14];
	logic I_LK_REQ_DIR = 0, I_LK_REQ_READ = 1, I_PRIOR_DONE = 0, I_PW_PENDING = 0, I_PW_LOCKED = 0;
	logic I_DLY_IS_READ = 0, hold = 0, busy = 0, serr = 0, I_P_IRDY_N = 1, I_S_IRDY_N = 1;
	logic I_SECONDARY_SYSERR_IN_N, I_P_LOCK_N, I_P_FRAME_N, I_S_LOCK_N, I_S_FRAME_N, O_PRIMARY_SYSERR_OUT_N;
	logic O_PRIMARY_SYSERR_OE, O_P_LOCK_N_OUT, O_P_LOCK_OE, O_S_LOCK_N_OUT, O_S_LOCK_OE, O_LK_CAPTURE;
	logic O_LK_RETRY_ALL, O_LK_BUS_REQ, O_LK_NO_PREFETCH, O_LK_FWD_LOCKED, O_LK_DATA_RET, O_LK_TABORT_RET;
	logic O_LK_MABORT_RET, O_PW_DISCARD, O_DLY_DISCARD, sl;
	logic [5:0] ctl;
	logic [7:0] dis, ex;
	int err_total = 0, num_checks = 0, cyc = 0, seed = 7, k;
	blsc_top #(.RETRY_LIMIT(RL)) dut_u (.*);
	blsc_far far_u (.i_clk(I_REF_CLK), .i_hold(hold), .i_busy(busy), .i_serr(serr), .i_s_oe(O_S_LOCK_OE),
		.i_s_out(O_S_LOCK_N_OUT), .o_p_lock_n(I_P_LOCK_N), .o_p_frame_n(I_P_FRAME_N), .o_s_lock_n(I_S_LOCK_N),
		.o_s_frame_n(I_S_FRAME_N), .o_secondary_syserr_in_n(I_SECONDARY_SYSERR_IN_N));
	initial forever #25 I_REF_CLK = ~I_REF_CLK;
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge I_REF_CLK);
		{I_PSEL, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, w, a, d};
		@(posedge I_REF_CLK) I_PENABLE <= 1;
		do @(posedge I_REF_CLK); while (O_PREADY !== 1'b1);
		q = O_PRDATA;
		sl = O_PSLVERR;
		{I_PSEL, I_PENABLE} <= 2'b00;
	endtask : apb
	task automatic pul(input int b, input int n);
		repeat (n) begin
			@(posedge I_REF_CLK) pv[b] <= 1;
			@(posedge I_REF_CLK) pv[b] <= 0;
		end
	endtask : pul
	function automatic logic [7:0] exp_cause(int k, logic [5:0] c, logic [7:0] d);
		// master timeout has its own enable bit and no disable bit
		return (c[0] && (k == 7 ? c[5] : !d[k]) && (k != 0 || c[3]) && (k != 4 || (c[1] && c[2])))
			? 8'h01 << k : 8'h00;
	endfunction : exp_cause
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	always @(posedge I_REF_CLK) if (++cyc == 20000) begin err_total++; summarize(); end
	initial begin
		repeat (12) @(posedge I_REF_CLK);
		I_NRST <= 1;
		foreach (ex[i]) begin
			apb(0, i < 5 ? 12'(i * 4) : i == 5 ? 12'h014 : 12'h118, 0);
			`CHK("reset", {i == 5, 32'(i == 4)}, {sl, q})
		end
		for (int n = 0; n < 24; n++) begin
			k = n < 8 ? n : $unsigned($random(seed)) % 8;
			ctl = n < 8 ? 6'h3f : 6'($random(seed));
			dis = n < 8 ? 8'h00 : 8'($random(seed));
			apb(1, 12'h000, {26'h0, ctl});
			apb(1, 12'h00c, {24'h0, dis});
			apb(1, 12'h008, 32'hff);
			apb(1, 12'h004, 32'hf);
			pul(7, 1);
			pul(8, 1);
			I_DLY_IS_READ <= k == 6;
			if (k == 0) begin serr <= 1; repeat (4) @(posedge I_REF_CLK); serr <= 0; end
			else pul(k > 6 ? 14 : k > 4 ? 13 : 8 + k, (k == 3 || k == 5 || k == 6) ? RL : 1);
			@(negedge I_REF_CLK);
			`CHK("discard", {k == 3, k == 5 || k == 6}, {O_PW_DISCARD, O_DLY_DISCARD})
			repeat (8) @(posedge I_REF_CLK);
			ex = exp_cause(k, ctl, dis);
			apb(0, 12'h008, 0);
			`CHK("cause", {24'h0, ex}, q)
			apb(0, 12'h004, 0);
			`CHK("status", {30'h0, k == 0 && ctl[3], |ex}, q)
		end
		busy <= 1;
		pul(0, 1); // opening transfer is a read
		@(negedge I_REF_CLK) `CHK("capture", 2'b11, {O_LK_CAPTURE, O_LK_RETRY_ALL})
		@(posedge I_REF_CLK) I_PRIOR_DONE <= 1;
		repeat (8) @(posedge I_REF_CLK);
		`CHK("busy request", 1'b0, O_LK_BUS_REQ)
		busy <= 0;
		repeat (8) @(posedge I_REF_CLK);
		`CHK("free request", 1'b1, O_LK_BUS_REQ)
		pul(1, 1);
		@(negedge I_REF_CLK) `CHK("address lock", 2'b11, {O_S_LOCK_OE, O_S_LOCK_N_OUT})
		pul(3, 1);
		@(negedge I_REF_CLK) `CHK("first retry", 1'b0, O_S_LOCK_OE)
		pul(1, 1);
		pul(2, 1);
		hold <= 1;
		repeat (6) @(posedge I_REF_CLK);
		pul(4, 1);
		@(negedge I_REF_CLK) `CHK("data", 3'b101, {O_LK_DATA_RET, O_LK_RETRY_ALL, O_LK_FWD_LOCKED})
		pul(3, 1);
		@(negedge I_REF_CLK) `CHK("later retry", 2'b10, {O_S_LOCK_OE, O_S_LOCK_N_OUT})
		@(posedge I_REF_CLK) hold <= 0;
		repeat (8) @(posedge I_REF_CLK);
		`CHK("release", 3'b010, {O_S_LOCK_OE, O_S_LOCK_N_OUT, O_LK_RETRY_ALL})
		for (int a = 0; a < 2; a++) begin
			apb(1, 12'h004, 32'hf);
			pul(0, 1);
			repeat (8) @(posedge I_REF_CLK);
			pul(1, 1);
			pul(5 + a, 1);
			pul(4, 1);
			@(negedge I_REF_CLK) `CHK("abort return", 2'b10 >> a, {O_LK_TABORT_RET, O_LK_MABORT_RET})
			apb(0, 12'h004, 0);
			`CHK("abort flag", 5'h04 << a, {O_LK_RETRY_ALL, q[3:0]})
		end
		apb(1, 12'h118, 32'h6000);
		I_LK_REQ_DIR <= 1;
		pul(0, 1);
		@(negedge I_REF_CLK) `CHK("ignored", 2'b00, {O_LK_CAPTURE, O_LK_RETRY_ALL})
		summarize();
	end
endmodule : tb_top
